// ==== rtl/acs_regs.vh ====
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// =====================================================================
// register byte addresses (word aligned)
// =====================================================================
`define ACS_ADDR_TIMING      6'h00
`define ACS_ADDR_SEQUENCE    6'h04
`define ACS_ADDR_STATUS      6'h08
`define ACS_ADDR_RESULT0     6'h20
`define ACS_ADDR_RES_BASE    3'h1

// =====================================================================
// timing register fields and reset value
// =====================================================================
`define ACS_TIM_RES_BIT      7
`define ACS_TIM_SMP_HI       6
`define ACS_TIM_SMP_LO       5
`define ACS_TIM_PRS_HI       4
`define ACS_TIM_PRS_LO       0
`define ACS_TIM_RESET        8'h01

// =====================================================================
// sequence register fields and reset value
// =====================================================================
`define ACS_SEQ_LEN_BIT      6
`define ACS_SEQ_SCAN_BIT     5
`define ACS_SEQ_MULTICHANNEL_ENABLE_BIT     4
`define ACS_SEQ_CH_HI        3
`define ACS_SEQ_CH_LO        0
`define ACS_SEQ_RESET        8'h00

// =====================================================================
// status register fields
// =====================================================================
`define ACS_STAT_SEQ_DONE    31
`define ACS_STAT_BUSY        30
`define ACS_STAT_CNT_HI      18
`define ACS_STAT_CNT_LO      16
`define ACS_STAT_CCF_HI      7
`define ACS_STAT_CCF_LO      0

// =====================================================================
// conversion timing in converter clock periods
// =====================================================================
`define ACS_BASE_8BIT        6'd16
`define ACS_BASE_10BIT       6'd18
`define ACS_SMP_CODE0        6'd2
`define ACS_SMP_CODE1        6'd4
`define ACS_SMP_CODE2        6'd8
`define ACS_SMP_CODE3        6'd16

`endif

// ==== rtl/acs_prescaler.v ====
`timescale 1ns/1ps
`include "acs_regs.vh"

// =====================================================================
// modulo prescaler followed by divide by two
// =====================================================================
module acs_prescaler (
   input  wire       mclk_i,
   input  wire       reset_n_i,
   input  wire       restart_i,
   input  wire [4:0] prescale_i,
   output reg        conv_clk_o,
   output reg        conv_tick_o
);

   reg  [4:0] count_q;
   wire       wrap;

   // zero divides by one: divide by two in total
   assign wrap = (count_q >= prescale_i);                   // R5 R6

   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_q     <= 5'h00;
         conv_clk_o  <= 1'b0;
         conv_tick_o <= 1'b0;
      end else if (restart_i) begin
         count_q     <= 5'h00;
         conv_clk_o  <= 1'b0;
         conv_tick_o <= 1'b0;
      end else begin
         conv_tick_o <= 1'b0;
         if (wrap) begin
            count_q    <= 5'h00;
            conv_clk_o <= ~conv_clk_o;                      // R5
            // tick marks each full converter period
            conv_tick_o <= conv_clk_o;
         end else begin
            count_q <= count_q + 5'h01;
         end
      end
   end

endmodule // acs_prescaler

// ==== rtl/acs_chan_map.v ====
`timescale 1ns/1ps
`include "acs_regs.vh"

// =====================================================================
// channel and result slot for a given conversion index
// =====================================================================
module acs_chan_map (
   input  wire       len8_i,
   input  wire       multichannel_enable_i,
   input  wire [3:0] chan_sel_i,
   input  wire [2:0] index_i,
   output reg  [3:0] channel_o,
   output reg  [2:0] slot_o
);

   always @* begin
      slot_o = index_i;                                     // R14 R17
      if (!multichannel_enable_i) begin
         channel_o = chan_sel_i;                            // R13
      end else if (len8_i) begin
         channel_o = {chan_sel_i[3], index_i};              // R16
      end else begin
         channel_o = {chan_sel_i[3:2], index_i[1:0]};       // R15
         slot_o    = {1'b0, index_i[1:0]};
      end
   end

endmodule // acs_chan_map

// ==== rtl/acs_adc_ctrl.v ====
// What this block does
// R1 - timing register write aborts conversion; halt until sequence write
// R2 - resolution bit: clear gives 8-bit results, set gives 10-bit
// R3 - sample field codes give 2, 4, 8, 16 converter clocks final sample
// R4 - total conversion 18/20/24/32 clocks 8-bit, 20/22/26/34 10-bit
// R5 - bus clock divided by prescale plus one, then divided by two
// R6 - prescale zero gives total divisor of two
// R7 - after reset prescale is one, total divisor four
// R8 - software uses only prescale codes zero to seven
// R9 - software keeps converter clock between 500 kHz and 2 MHz
// R10 - sequence write starts sequence, aborts old, clears all flags
// R11 - length bit: four conversions when clear, eight when set
// R12 - scan bit: clear stops after one sequence, set repeats
// R13 - single channel mode converts the selected input every time
// R14 - multichannel mode steps through group, one result register each
// R15 - four-long groups chosen by two upper select bits, slots 0-3
// R16 - eight-long groups chosen by top select bit, slots 0-7
// R17 - single channel results fill successive registers from zero
// R18 - sequence done flag set at end; halt or keep scanning
// R19 - per register done flag set on load, cleared on read
// R20 - results left-justified unsigned, not writable by software
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "acs_regs.vh"

module acs_adc_ctrl (
   input  wire        mclk_i,
   input  wire        reset_n_i,
   // avalon-mm slave
   input  wire [5:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   input  wire [3:0]  avs_byteenable_i,
   output reg  [31:0] avs_readdata_o,
   output reg         avs_waitrequest_o,
   // converter core
   output reg         conv_clk_o,
   output reg  [3:0]  channel_o,
   output reg         sample_o,
   output reg         convert_o,
   output reg         resolution_o,
   input  wire        conv_done_i,
   input  wire [9:0]  conv_data_i,
   output reg         busy_o
);

   // =================================================================
   // register state
   // =================================================================
   reg  [7:0]  timing_q;
   reg  [7:0]  sequence_q;
   reg  [7:0]  ccf_q;
   reg         seq_done_q;
   reg         active_q;
   reg  [2:0]  index_q;
   reg  [5:0]  phase_q;
   reg  [15:0] result_q [0:7];
   reg         ack_q;
   reg         done_s1_q;
   reg         done_s2_q;
   reg  [9:0]  data_s1_q;
   reg  [9:0]  data_s2_q;

   wire        conv_clk;
   wire        conv_tick;
   wire [3:0]  map_chan;
   wire [2:0]  map_slot;

   // =================================================================
   // bus decode
   // =================================================================
   wire        req      = avs_read_i | avs_write_i;
   wire        take     = req & ~ack_q;
   wire        wr_take  = take & avs_write_i & avs_byteenable_i[0];
   wire        rd_take  = take & avs_read_i;
   wire        wr_tim   = wr_take & (avs_address_i == `ACS_ADDR_TIMING);
   wire        wr_seq   = wr_take & (avs_address_i == `ACS_ADDR_SEQUENCE);
   // same-edge restart: no stale tick may advance the first phase
   wire        restart  = wr_tim | wr_seq;                  // R1 R10
   wire        rd_res   = rd_take &
                          (avs_address_i[5:3] >= `ACS_ADDR_RES_BASE) &&
                          (avs_address_i[1:0] == 2'b00) &&
                          (avs_address_i >= `ACS_ADDR_RESULT0);
   wire [2:0]  rd_slot  = avs_address_i[4:2];

   // =================================================================
   // configuration fields
   // =================================================================
   wire        res10    = timing_q[`ACS_TIM_RES_BIT];
   wire [1:0]  smp      = timing_q[`ACS_TIM_SMP_HI:`ACS_TIM_SMP_LO];
   wire [4:0]  prs      = timing_q[`ACS_TIM_PRS_HI:`ACS_TIM_PRS_LO];
   wire        len8     = sequence_q[`ACS_SEQ_LEN_BIT];
   wire        scan     = sequence_q[`ACS_SEQ_SCAN_BIT];
   wire        multichannel_enable     = sequence_q[`ACS_SEQ_MULTICHANNEL_ENABLE_BIT];
   wire [3:0]  chsel    = sequence_q[`ACS_SEQ_CH_HI:`ACS_SEQ_CH_LO];

   reg  [5:0]  smp_len;
   always @* begin
      case (smp)                                            // R3
         2'b00:   smp_len = `ACS_SMP_CODE0;
         2'b01:   smp_len = `ACS_SMP_CODE1;
         2'b10:   smp_len = `ACS_SMP_CODE2;
         default: smp_len = `ACS_SMP_CODE3;
      endcase
   end

   // total periods per conversion, last index is total minus one
   wire [5:0]  total    = (res10 ? `ACS_BASE_10BIT : `ACS_BASE_8BIT)
                          + smp_len;                        // R4
   wire [5:0]  smp_end  = total - 6'd1;
   wire [5:0]  smp_begin= total - smp_len;
   wire [2:0]  last_idx = len8 ? 3'd7 : 3'd3;               // R11

   acs_prescaler u_presc (
      .mclk_i      (mclk_i),
      .reset_n_i   (reset_n_i),
      .restart_i   (restart),
      .prescale_i  (prs),
      .conv_clk_o  (conv_clk),
      .conv_tick_o (conv_tick)
   );

   acs_chan_map u_map (
      .len8_i     (len8),
      .multichannel_enable_i     (multichannel_enable),
      .chan_sel_i (chsel),
      .index_i    (index_q),
      .channel_o  (map_chan),
      .slot_o     (map_slot)
   );

   // =================================================================
   // converter done synchroniser
   // =================================================================
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         done_s1_q <= 1'b0;
         done_s2_q <= 1'b0;
         data_s1_q <= 10'h000;
         data_s2_q <= 10'h000;
      end else begin
         done_s1_q <= conv_done_i;
         done_s2_q <= done_s1_q;
         data_s1_q <= conv_data_i;
         data_s2_q <= data_s1_q;
      end
   end

   // conversion ends on the last period of its budget
   wire        conv_end = active_q & conv_tick & (phase_q == smp_end);
   wire        seq_end  = conv_end & (index_q == last_idx);
   // 8-bit mode drops the two low result bits
   wire [15:0] res_word = res10 ? {data_s2_q, 6'h00}
                                : {data_s2_q[9:2], 8'h00};  // R2 R20

   // =================================================================
   // sequencer
   // =================================================================
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         timing_q   <= `ACS_TIM_RESET;                      // R7
         sequence_q <= `ACS_SEQ_RESET;
         active_q   <= 1'b0;
         index_q    <= 3'd0;
         phase_q    <= 6'd0;
         seq_done_q <= 1'b0;
      end else begin
         if (wr_tim) begin
            timing_q <= avs_writedata_i[7:0];
            active_q <= 1'b0;                               // R1
            phase_q  <= 6'd0;
         end else if (wr_seq) begin
            sequence_q <= avs_writedata_i[7:0];
            active_q   <= 1'b1;                             // R10
            index_q    <= 3'd0;
            phase_q    <= 6'd0;
            seq_done_q <= 1'b0;                             // R10
         end else if (active_q && conv_tick) begin
            if (phase_q == smp_end) begin
               phase_q <= 6'd0;
               index_q <= (index_q == last_idx) ? 3'd0
                                                : index_q + 3'd1; // R17
               if (index_q == last_idx) begin
                  seq_done_q <= 1'b1;                       // R18
                  active_q   <= scan;                       // R12
               end
            end else begin
               phase_q <= phase_q + 6'd1;
            end
         end
      end
   end

   // =================================================================
   // results and done flags
   // =================================================================
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_res
         always @(posedge mclk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               ccf_q[g]    <= 1'b0;
               result_q[g] <= 16'h0000;
            end else if (wr_seq) begin
               ccf_q[g] <= 1'b0;                            // R10
            end else if (conv_end && map_slot == g) begin
               // set beats a read in the same cycle
               ccf_q[g]    <= 1'b1;                         // R19
               result_q[g] <= res_word;                     // R20
            end else if (rd_res && rd_slot == g) begin
               ccf_q[g] <= 1'b0;                            // R19
            end
         end
      end
   endgenerate

   // =================================================================
   // bus answer: one wait cycle, then ack
   // =================================================================
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ack_q             <= 1'b0;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
      end else begin
         ack_q             <= take;
         avs_waitrequest_o <= ~take;
         if (rd_take) begin
            if (avs_address_i == `ACS_ADDR_TIMING)
               avs_readdata_o <= {24'h000000, timing_q};
            else if (avs_address_i == `ACS_ADDR_SEQUENCE)
               avs_readdata_o <= {24'h000000, sequence_q};
            else if (avs_address_i == `ACS_ADDR_STATUS)
               avs_readdata_o <= {seq_done_q, active_q, 11'h000,
                                  index_q, 8'h00, ccf_q};
            else if (rd_res)
               avs_readdata_o <= {16'h0000, result_q[rd_slot]};
            else
               avs_readdata_o <= 32'h0000_0000;
         end
      end
   end

   // =================================================================
   // converter core outputs
   // =================================================================
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         conv_clk_o   <= 1'b0;
         channel_o    <= 4'h0;
         sample_o     <= 1'b0;
         convert_o    <= 1'b0;
         resolution_o <= 1'b0;
         busy_o       <= 1'b0;
      end else begin
         conv_clk_o   <= conv_clk & active_q;
         channel_o    <= map_chan;                          // R13 R14
         sample_o     <= active_q & (phase_q >= smp_begin); // R3
         convert_o    <= active_q & (phase_q < smp_begin);
         resolution_o <= res10;                             // R2
         busy_o       <= active_q;
      end
   end

endmodule // acs_adc_ctrl

// ==== bench/acs_core_model.sv ====
`timescale 1ns/1ps
// ==============================
// converter core stand-in
module acs_core_model (
   input  wire       mclk_i,
   input  wire [3:0] channel_i,
   input  wire       active_i,
   output reg        done_o,
   output reg  [9:0] data_o
);
   initial begin
      done_o = 1'b0;
      data_o = 10'h000;
   end
   // value names its channel; idle bus keeps flipping
   always @(posedge mclk_i) begin
      done_o <= active_i;
      if (active_i) begin
         data_o <= {channel_i, 6'h15};
      end else begin
         data_o <= ~data_o;
      end
   end
endmodule // acs_core_model

// ==== bench/acs_adc_ctrl_monitor.sv ====
`timescale 1ns/1ps
// ==============================
// bus and sequencer checks
module acs_adc_ctrl_monitor (
   input wire        mclk_i,
   input wire        reset_n_i,
   input wire [5:0]  avs_address_i,
   input wire        avs_read_i,
   input wire        avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0]  avs_byteenable_i,
   input wire [31:0] avs_readdata_o,
   input wire        avs_waitrequest_o,
   input wire        conv_clk_o,
   input wire [3:0]  channel_o,
   input wire        sample_o,
   input wire        convert_o,
   input wire        resolution_o,
   input wire        busy_o
);
   reg        res_q;
   reg  [7:0] sel_q;
   wire       acc_w;
   wire       act;
   assign acc_w = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   assign act   = sample_o || convert_o;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   // shadow of the last accepted control writes
   always @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         res_q <= 1'b0;
         sel_q <= 8'h00;
      end else if (acc_w && avs_address_i == 6'h00) begin
         res_q <= avs_writedata_i[7];
      end else if (acc_w && avs_address_i == 6'h04) begin
         sel_q <= avs_writedata_i[7:0];
      end
   end
   sequence s_req_new;
      (avs_read_i || avs_write_i) && avs_waitrequest_o
         && $past(avs_waitrequest_o);
   endsequence
   sequence s_tim_wr;
      acc_w && avs_address_i == 6'h00;
   endsequence
   sequence s_seq_wr;
      acc_w && avs_address_i == 6'h04;
   endsequence
   chk_bus_answer: assert property (s_req_new |=> !avs_waitrequest_o)
      else $error("request not answered");
   chk_ack_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("ack longer than one cycle");
   chk_hole_zero: assert property (avs_read_i && !avs_waitrequest_o
      && avs_address_i == 6'h0C |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   chk_phase_excl: assert property (!(sample_o && convert_o))
      else $error("sample and convert together");
   chk_idle_quiet: assert property (!busy_o && !$past(busy_o) |->
      !act && !conv_clk_o)
      else $error("activity while idle");
   chk_timing_abort: assert property (s_tim_wr |-> ##[1:3] !busy_o)
      else $error("timing write did not halt");
   chk_seq_start: assert property (s_seq_wr |-> ##[1:3] busy_o)
      else $error("sequence write did not start");
   chk_res_follow: assert property ($rose(busy_o) |->
      ##[0:2] resolution_o == res_q)
      else $error("resolution mismatch");
   chk_single_chan: assert property (busy_o && act && !sel_q[4] |->
      channel_o == sel_q[3:0])
      else $error("single channel mismatch");
   chk_group_chan: assert property (busy_o && act && sel_q[4]
      && !sel_q[6] |-> channel_o[3:2] == sel_q[3:2])
      else $error("group mismatch");
endmodule // acs_adc_ctrl_monitor

bind acs_adc_ctrl acs_adc_ctrl_monitor i_acs_adc_ctrl_monitor (.mclk_i,
   .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
   .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .conv_clk_o,
   .channel_o, .sample_o, .convert_o, .resolution_o, .busy_o);

// ==== bench/acs_adc_ctrl_test.sv ====
`timescale 1ns/1ps
module acs_adc_ctrl_test;
   localparam [55:0] MODES = 56'h46_58_50_18_1C_14_06;
   reg         mclk_i, reset_n_i, avs_read_i, avs_write_i;
   reg  [5:0]  avs_address_i;
   reg  [31:0] avs_writedata_i, got;
   reg  [3:0]  avs_byteenable_i;
   reg  [7:0]  md;
   reg         pc;
   wire [31:0] avs_readdata_o;
   wire        avs_waitrequest_o, conv_clk_o, sample_o, convert_o;
   wire        resolution_o, conv_done_i, busy_o;
   wire [3:0]  channel_o;
   wire [9:0]  conv_data_i;
   integer     num_errors, compares, cyc, i, k, n, sc, tc, t0;
   acs_adc_ctrl i_acs_adc_ctrl (.mclk_i, .reset_n_i, .avs_address_i,
      .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
      .avs_readdata_o, .avs_waitrequest_o, .conv_clk_o, .channel_o,
      .sample_o, .convert_o, .resolution_o, .conv_done_i, .conv_data_i,
      .busy_o);
   acs_core_model i_acs_core_model (.mclk_i(mclk_i), .channel_i(channel_o),
      .active_i(sample_o | convert_o), .done_o(conv_done_i),
      .data_o(conv_data_i));
   // ==============================
   // helpers
   function [31:0] eres(input [7:0] m, input [2:0] s, input r);
      reg [3:0] c;
      begin
         c = !m[4] ? m[3:0] : m[6] ? {m[3], s} : {m[3:2], s[1:0]};
         eres = {16'h0, c, r ? 12'h540 : 12'h500};
      end
   endfunction
   task check(input [31:0] g, input [31:0] e);
      begin
         compares = compares + 1;
         if (g !== e) begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task bus(input w, input [5:0] a, input [7:0] d);
      begin
         avs_read_i <= !w;
         avs_write_i <= w;
         avs_address_i <= a;
         avs_writedata_i <= {24'h0, d};
         @(posedge mclk_i);
         while (avs_waitrequest_o !== 1'b0) @(posedge mclk_i);
         got = avs_readdata_o;
         avs_read_i <= 1'b0;
         avs_write_i <= 1'b0;
         @(posedge mclk_i);
      end
   endtask
   task per;
      begin
         @(posedge conv_clk_o);
         t0 = cyc;
         @(posedge conv_clk_o);
         n = cyc - t0;
      end
   endtask
   // waits for the sequence end, counting phase cycles
   task run_out;
      begin
         sc = 0;
         tc = 0;
         n = 0;
         pc = 1'b0;
         @(posedge mclk_i);
         while (busy_o !== 1'b0 && n < 6000) begin
            sc = sc + sample_o;
            // converter periods counted as rising converter clock edges
            tc = tc + (conv_clk_o & ~pc);
            pc = conv_clk_o;
            n = n + 1;
            @(posedge mclk_i);
         end
         if (n >= 6000) begin
            num_errors = num_errors + 1;
            $display("BAD t=%0t run_out limit %h", $time, n);
         end
      end
   endtask
   task close_out;
      begin
         $display("errors %0d compares %0d", num_errors, compares);
         if (num_errors == 0 && compares > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   // ==============================
   // clock and timeout
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      cyc = cyc + 1;
      if (cyc == 40000) begin
         num_errors = num_errors + 1;
         close_out;
      end
   end
   // ==============================
   // tests
   initial begin
      {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = 0;
      avs_byteenable_i = 4'hF;
      reset_n_i = 1'b0;
      num_errors = 0;
      compares = 0;
      cyc = 0;
      repeat (5) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      bus(0, 6'h00, 8'h00);
      check(got, 32'h01);
      bus(0, 6'h04, 8'h00);
      check(got, 32'h00);
      bus(0, 6'h0C, 8'h00);
      check(got, 32'h00);
      bus(1, 6'h04, 8'h00);
      per;
      check(n, 4);
      run_out;
      for (i = 0; i < 8; i = i + 1) begin
         bus(1, 6'h00, i[7:0]);
         bus(1, 6'h04, 8'h00);
         per;
         check(n, 2 * i + 2);
         run_out;
      end
      for (i = 0; i < 8; i = i + 1) begin
         bus(1, 6'h00, {i[2:0], 5'h00});
         bus(1, 6'h04, 8'h00);
         run_out;
         check(sc, 16 << i[1:0]);
         check(tc, (i[2] ? 72 : 64) + (8 << i[1:0]));
      end
      for (i = 0; i < 7; i = i + 1) begin
         md = MODES[i*8 +: 8];
         bus(1, 6'h00, {i[0], 7'h00});
         bus(1, 6'h04, md);
         run_out;
         bus(0, 6'h08, 8'h00);
         check(got & 32'hC00000FF, md[6] ? 32'h800000FF : 32'h8000000F);
         for (k = 0; k < (md[6] ? 8 : 4); k = k + 1) begin
            bus(0, {1'b1, k[2:0], 2'b00}, 8'h00);
            check(got, eres(md, k[2:0], i[0]));
         end
         bus(0, 6'h08, 8'h00);
         check(got & 32'hFF, 32'h0);
      end
      bus(1, 6'h20, 8'hAA);
      bus(0, 6'h20, 8'h00);
      check(got, eres(8'h46, 3'd0, 1'b0));
      bus(1, 6'h00, 8'h00);
      bus(1, 6'h04, 8'h20);
      repeat (200) @(posedge mclk_i);
      bus(0, 6'h08, 8'h00);
      check(got & 32'hC000000F, 32'hC000000F);
      bus(1, 6'h04, 8'h20);
      bus(0, 6'h08, 8'h00);
      check(got & 32'h8000000F, 32'h0);
      repeat (50) @(posedge mclk_i);
      bus(1, 6'h00, 8'h00);
      repeat (300) @(posedge mclk_i);
      check({31'h0, busy_o}, 32'h0);
      close_out;
   end
endmodule // acs_adc_ctrl_test
